// >>> logic/sdh_pkg.sv
package sdh_pkg;
  // Card clock rates; the half periods round up so the card is never overclocked
  localparam int unsigned SYS_CLK_HZ   = 100_000_000;
  localparam int unsigned ID_CLK_HZ    = 400_000;
  localparam int unsigned XFER_CLK_HZ  = 25_000_000;
  localparam int unsigned HALF_ID      = (SYS_CLK_HZ + 2 * ID_CLK_HZ - 1) / (2 * ID_CLK_HZ);
  localparam int unsigned HALF_XFER    = (SYS_CLK_HZ + 2 * XFER_CLK_HZ - 1) / (2 * XFER_CLK_HZ);
  localparam logic [7:0]  HALF_ID_LAST   = 8'(HALF_ID - 1);
  localparam logic [7:0]  HALF_XFER_LAST = 8'(HALF_XFER - 1);

  // Counts in card clocks, except OPC_TRIES which counts operating-condition tries
  localparam int unsigned WARM_CLKS      = 74;
  localparam int unsigned GAP_CLKS       = 2;
  localparam int unsigned RESP_WAIT_CLKS = 64;
  localparam logic [7:0]  WARM_LAST      = 8'(WARM_CLKS - 1);
  localparam logic [7:0]  GAP_LAST       = 8'(GAP_CLKS - 1);
  localparam logic [7:0]  RESP_WAIT_LAST = 8'(RESP_WAIT_CLKS - 1);
  localparam logic [7:0]  CMD_LEN        = 8'd48;
  localparam logic [7:0]  LONG_LEN       = 8'd136;
  localparam logic [15:0] OPC_TRIES      = 16'd1000;
  localparam int unsigned DATA_WAIT_CLKS = 100_000;

  // Data block layout
  localparam int unsigned BLK_BYTES  = 512;
  localparam int unsigned DATA_BITS  = BLK_BYTES * 8;
  localparam logic [12:0] DATA_LAST  = 13'(DATA_BITS - 1);
  localparam logic [12:0] CRC16_LAST = 13'd15;
  localparam logic [15:0] CRC16_POLY = 16'h1021;
  localparam logic [6:0]  CRC7_POLY  = 7'h09;
  localparam int unsigned BLK_SHIFT  = 9;

  // Command indices and arguments
  localparam logic [5:0]  IX_GO_IDLE  = 6'h00;
  localparam logic [5:0]  IX_CID      = 6'h02;
  localparam logic [5:0]  IX_RCA      = 6'h03;
  localparam logic [5:0]  IX_SELECT   = 6'h07;
  localparam logic [5:0]  IX_IF_COND  = 6'h08;
  localparam logic [5:0]  IX_STOP     = 6'h0c;
  localparam logic [5:0]  IX_BLKLEN   = 6'h10;
  localparam logic [5:0]  IX_RD_ONE   = 6'h11;
  localparam logic [5:0]  IX_RD_MULTI = 6'h12;
  localparam logic [5:0]  IX_OPCOND   = 6'h29;
  localparam logic [5:0]  IX_APP      = 6'h37;
  localparam logic [5:0]  IX_WIRED    = 6'h3f;
  localparam logic [7:0]  WIRED_TAIL  = 8'hff;
  localparam logic [31:0] IF_COND_ARG = 32'h0000_01aa;
  localparam logic [31:0] OPCOND_ARG  = 32'h40ff_8000;
  localparam logic [31:0] BLKLEN_ARG  = 32'h0000_0200;
  localparam int unsigned OCR_READY   = 31;
  localparam int unsigned OCR_CCS     = 30;

  typedef enum logic [1:0] {
    RK_NONE  = 2'h0,
    RK_SHORT = 2'h1,
    RK_WIRED = 2'h2,
    RK_LONG  = 2'h3
  } sdh_rkind_type;

  typedef struct packed {
    logic [5:0]    idx;
    logic [31:0]   arg;
    sdh_rkind_type kind;
  } sdh_cmd_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } sdh_byte_type;

  typedef struct packed {
    logic crc;
    logic timeout;
    logic resp;
  } sdh_err_type;

  function automatic logic [6:0] sdh_crc7(input logic [39:0] d);
    logic [6:0] c;
    logic       fb;
    c = 7'h00;
    for (int i = 39; i >= 0; i--) begin
      fb = c[6] ^ d[i];
      c  = {c[5:0], 1'b0};
      if (fb) begin
        c = c ^ CRC7_POLY;
      end
    end
    return c;
  endfunction

  function automatic logic [47:0] sdh_frame(input logic [5:0] idx, input logic [31:0] arg);
    return {2'b01, idx, arg, sdh_crc7({2'b01, idx, arg}), 1'b1};
  endfunction
endpackage

// >>> logic/sdh_dat_rx.sv
`timescale 1ns/100ps
module sdh_dat_rx
  import sdh_pkg::*;
#(
  parameter int unsigned WAIT_CLKS = DATA_WAIT_CLKS
) (
  // Clock and control
  input  wire logic   i_core_clk,
  input  wire logic   i_sys_rst,
  input  wire logic   i_ce,
  input  wire logic   i_arm,
  input  wire logic   i_tick,
  input  wire logic   i_bit,
  // Results
  output sdh_byte_type o_byte,
  output logic         o_blk_done,
  output logic         o_crc_bad,
  output logic         o_timeout
);
  typedef enum logic [3:0] {
    R_WAIT = 4'b0001,
    R_DATA = 4'b0010,
    R_CRC  = 4'b0100,
    R_STOP = 4'b1000
  } sdh_rph_type;

  sdh_rph_type ph_q;
  logic [12:0] cnt_q;
  logic [15:0] crc_q;
  logic [15:0] rcv_q;
  logic [31:0] wait_q;

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      ph_q       <= R_WAIT;
      cnt_q      <= '0;
      crc_q      <= '0;
      rcv_q      <= '0;
      wait_q     <= '0;
      o_byte     <= '0;
      o_blk_done <= 1'b0;
      o_crc_bad  <= 1'b0;
      o_timeout  <= 1'b0;
    end else if (i_ce) begin
      o_byte.valid <= 1'b0;
      o_blk_done   <= 1'b0;
      o_crc_bad    <= 1'b0;
      o_timeout    <= 1'b0;
      if (!i_arm) begin
        ph_q   <= R_WAIT;
        wait_q <= '0;
      end else if (i_tick) begin
        case (ph_q)
          R_WAIT: begin
            if (!i_bit) begin
              ph_q   <= R_DATA;
              cnt_q  <= '0;
              crc_q  <= '0;
              wait_q <= '0;
            end else if (wait_q == 32'(WAIT_CLKS - 1)) begin
              o_timeout <= 1'b1;
              wait_q    <= '0;
            end else begin
              wait_q <= wait_q + 32'd1;
            end
          end
          R_DATA: begin
            // Payload only, MSB first
            crc_q <= {crc_q[14:0], 1'b0} ^ ((crc_q[15] ^ i_bit) ? CRC16_POLY : 16'h0000);
            rcv_q <= {rcv_q[14:0], i_bit};
            cnt_q <= cnt_q + 13'd1;
            if (cnt_q[2:0] == 3'h7) begin
              o_byte <= '{valid: 1'b1, data: {rcv_q[6:0], i_bit}};
            end
            if (cnt_q == DATA_LAST) begin
              ph_q  <= R_CRC;
              cnt_q <= '0;
            end
          end
          R_CRC: begin
            rcv_q <= {rcv_q[14:0], i_bit};
            cnt_q <= cnt_q + 13'd1;
            if (cnt_q == CRC16_LAST) begin
              ph_q <= R_STOP;
            end
          end
          R_STOP: begin
            o_blk_done <= 1'b1;
            o_crc_bad  <= (rcv_q != crc_q) || !i_bit;
            ph_q       <= R_WAIT;
          end
          default: ph_q <= R_WAIT;
        endcase
      end
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  property p_blk_len;
    (ph_q == R_CRC && $past(ph_q) == R_DATA) |-> $past(cnt_q) == DATA_LAST;
  endproperty
  a_blk_len: assert property (p_blk_len) else $error("data block length wrong");

  property p_crc_verdict;
    (i_ce && i_arm && i_tick && ph_q == R_STOP && rcv_q != crc_q) |=> o_crc_bad && o_blk_done;
  endproperty
  a_crc_verdict: assert property (p_crc_verdict) else $error("crc mismatch missed");
endmodule

// >>> logic/sdh_host.sv
`timescale 1ns/100ps
module sdh_host
  import sdh_pkg::*;
#(
  parameter int unsigned DATA_WAIT = DATA_WAIT_CLKS,
  parameter logic [15:0] OPC_LIMIT = OPC_TRIES,
  // Identification half period; a bench may shorten it to save run time
  parameter logic [7:0]  ID_HALF_LAST = HALF_ID_LAST
) (
  // Clock, reset, enable
  input  wire logic        i_core_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_ce,
  // Read request
  input  wire logic        i_rd_start,
  input  wire logic [31:0] i_rd_block,
  input  wire logic [15:0] i_rd_count,
  // Status and data
  output logic             o_ready,
  output logic             o_busy,
  output logic             o_hc_card,
  output sdh_byte_type     o_rd_byte,
  output logic             o_blk_done,
  output sdh_err_type      o_err,
  // Card pins
  output logic             o_sd_clk,
  input  wire logic        i_sd_cmd,
  output logic             o_sd_cmd,
  output logic             o_sd_cmd_oe,
  input  wire logic        i_sd_dat0,
  output logic             o_sd_dat0,
  output logic             o_sd_dat0_oe
);
  typedef enum logic [12:0] {
    S_WARM  = 13'h0001,
    S_CMD0  = 13'h0002,
    S_CMD8  = 13'h0004,
    S_APP   = 13'h0008,
    S_OPC   = 13'h0010,
    S_CID   = 13'h0020,
    S_RCA   = 13'h0040,
    S_SEL   = 13'h0080,
    S_BLEN  = 13'h0100,
    S_READY = 13'h0200,
    S_RD    = 13'h0400,
    S_STOP  = 13'h0800,
    S_FAIL  = 13'h1000
  } sdh_state_type;

  typedef enum logic [4:0] {
    E_IDLE = 5'b00001,
    E_SEND = 5'b00010,
    E_GAP  = 5'b00100,
    E_WAIT = 5'b01000,
    E_RECV = 5'b10000
  } sdh_eph_type;

  sdh_state_type st_q, st_d;
  sdh_eph_type   eph_q;
  sdh_cmd_type   cmd_req, cmd_q;
  logic [7:0]    div_q, bcnt_q, wcnt_q, warm_q;
  logic [47:0]   sh_q, nsh;
  logic [31:0]   resp_arg_q, rd_arg_q;
  logic [15:0]   tries_q, rca_q, left_q;
  logic          sclk_q, fast_q, clk_run, div_end, tick;
  logic          cmd_m_q, cmd_s_q, dat_m_q, dat_s_q;
  logic          cmd_go, issued_q, done_q, ok_q, to_q, mine, rsp_good;
  logic          multi_q, seen_q, dat_out_q, rx_done, rx_crc, rx_to, rd_take;
  sdh_err_type   err_ev;

  // Card clock from a divider; slow until selected
  assign clk_run = !(st_q inside {S_READY, S_FAIL});
  assign div_end = div_q == (fast_q ? HALF_XFER_LAST : ID_HALF_LAST);
  assign tick    = i_ce && clk_run && div_end && sclk_q;

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      div_q  <= '0;
      sclk_q <= 1'b0;
    end else if (i_ce) begin
      if (!clk_run) begin
        div_q  <= '0;
        sclk_q <= 1'b0;
      end else if (div_end) begin
        div_q  <= '0;
        sclk_q <= !sclk_q;
      end else begin
        div_q <= div_q + 8'd1;
      end
    end
  end

  // Line samples taken on the falling edge reflect the level seen at the rise,
  // since the synchroniser lags by two cycles and the card only changes on fall
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      {cmd_m_q, cmd_s_q, dat_m_q, dat_s_q} <= 4'hf;
    end else if (i_ce) begin
      cmd_m_q <= i_sd_cmd;
      cmd_s_q <= cmd_m_q;
      dat_m_q <= i_sd_dat0;
      dat_s_q <= dat_m_q;
    end
  end

  // Response evaluation on the shift value including the final bit
  assign nsh = {sh_q[46:0], cmd_s_q};
  always_comb begin
    logic crc_ok;
    logic idx_ok;
    crc_ok = sdh_crc7(nsh[47:8]) == nsh[7:1] && nsh[0] && !nsh[46];
    idx_ok = nsh[45:40] == cmd_q.idx;
    case (cmd_q.kind)
      RK_SHORT: rsp_good = crc_ok && idx_ok;
      RK_WIRED: rsp_good = (nsh[45:40] == IX_WIRED && nsh[7:0] == WIRED_TAIL)
                           || (crc_ok && idx_ok);
      RK_LONG:  rsp_good = nsh[0];
      default:  rsp_good = 1'b1;
    endcase
  end

  // Command engine
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      eph_q       <= E_IDLE;
      cmd_q       <= '0;
      sh_q        <= '0;
      bcnt_q      <= '0;
      wcnt_q      <= '0;
      done_q      <= 1'b0;
      ok_q        <= 1'b0;
      to_q        <= 1'b0;
      resp_arg_q  <= '0;
      o_sd_cmd    <= 1'b1;
      o_sd_cmd_oe <= 1'b1;
    end else if (i_ce) begin
      done_q <= 1'b0;
      case (eph_q)
        E_IDLE: begin
          if (cmd_go) begin
            cmd_q  <= cmd_req;
            sh_q   <= sdh_frame(cmd_req.idx, cmd_req.arg);
            bcnt_q <= '0;
            eph_q  <= E_SEND;
          end else if (tick) begin
            o_sd_cmd_oe <= st_q == S_WARM;
            o_sd_cmd    <= 1'b1;
          end
        end
        E_SEND: begin
          if (tick) begin
            if (bcnt_q == CMD_LEN) begin
              o_sd_cmd_oe <= 1'b0;
              o_sd_cmd    <= 1'b1;
              wcnt_q      <= '0;
              eph_q       <= E_GAP;
            end else begin
              o_sd_cmd_oe <= 1'b1;
              o_sd_cmd    <= sh_q[47];
              sh_q        <= {sh_q[46:0], 1'b1};
              bcnt_q      <= bcnt_q + 8'd1;
            end
          end
        end
        E_GAP: begin
          if (tick) begin
            wcnt_q <= wcnt_q + 8'd1;
            if (wcnt_q == GAP_LAST) begin
              wcnt_q <= '0;
              if (cmd_q.kind == RK_NONE) begin
                done_q <= 1'b1;
                ok_q   <= 1'b1;
                to_q   <= 1'b0;
                eph_q  <= E_IDLE;
              end else begin
                eph_q <= E_WAIT;
              end
            end
          end
        end
        E_WAIT: begin
          if (tick) begin
            if (!cmd_s_q) begin
              sh_q   <= nsh;
              bcnt_q <= 8'd1;
              eph_q  <= E_RECV;
            end else if (wcnt_q == RESP_WAIT_LAST) begin
              done_q <= 1'b1;
              ok_q   <= 1'b0;
              to_q   <= 1'b1;
              eph_q  <= E_IDLE;
            end else begin
              wcnt_q <= wcnt_q + 8'd1;
            end
          end
        end
        E_RECV: begin
          if (tick) begin
            sh_q   <= nsh;
            bcnt_q <= bcnt_q + 8'd1;
            if (bcnt_q == ((cmd_q.kind == RK_LONG) ? LONG_LEN : CMD_LEN) - 8'd1) begin
              done_q     <= 1'b1;
              ok_q       <= rsp_good;
              to_q       <= 1'b0;
              resp_arg_q <= nsh[39:8];
              eph_q      <= E_IDLE;
            end
          end
        end
        default: eph_q <= E_IDLE;
      endcase
    end
  end

  // Command chosen by sequence state
  always_comb begin
    cmd_req = '{idx: IX_GO_IDLE, arg: 32'h0, kind: RK_NONE};
    case (st_q)
      S_CMD8:  cmd_req = '{idx: IX_IF_COND, arg: IF_COND_ARG, kind: RK_WIRED};
      S_APP:   cmd_req = '{idx: IX_APP, arg: 32'h0, kind: RK_SHORT};
      S_OPC:   cmd_req = '{idx: IX_OPCOND, arg: OPCOND_ARG, kind: RK_WIRED};
      S_CID:   cmd_req = '{idx: IX_CID, arg: 32'h0, kind: RK_LONG};
      S_RCA:   cmd_req = '{idx: IX_RCA, arg: 32'h0, kind: RK_SHORT};
      S_SEL:   cmd_req = '{idx: IX_SELECT, arg: {rca_q, 16'h0}, kind: RK_SHORT};
      S_BLEN:  cmd_req = '{idx: IX_BLKLEN, arg: BLKLEN_ARG, kind: RK_SHORT};
      S_RD:    cmd_req = '{idx: multi_q ? IX_RD_MULTI : IX_RD_ONE, arg: rd_arg_q,
                           kind: RK_SHORT};
      S_STOP:  cmd_req = '{idx: IX_STOP, arg: 32'h0, kind: RK_SHORT};
      default: cmd_req = '{idx: IX_GO_IDLE, arg: 32'h0, kind: RK_NONE};
    endcase
  end

  assign cmd_go  = i_ce && !issued_q && eph_q == E_IDLE
                   && !(st_q inside {S_WARM, S_READY, S_FAIL});
  // A stale answer from an abandoned command is ignored by the next state
  assign mine    = done_q && issued_q;
  assign rd_take = st_q == S_READY && i_rd_start && i_rd_count != 16'h0;

  always_comb begin
    st_d = st_q;
    case (st_q)
      S_WARM:  if (tick && warm_q == WARM_LAST) st_d = S_CMD0;
      S_CMD0:  if (mine) st_d = S_CMD8;
      S_CMD8:  if (mine) st_d = S_APP;
      S_APP:   if (mine) st_d = ok_q ? S_OPC : S_FAIL;
      S_OPC: begin
        if (mine) begin
          if (!ok_q || (!resp_arg_q[OCR_READY] && tries_q == OPC_LIMIT - 16'd1)) begin
            st_d = S_FAIL;
          end else begin
            st_d = resp_arg_q[OCR_READY] ? S_CID : S_APP;
          end
        end
      end
      S_CID:   if (mine) st_d = ok_q ? S_RCA : S_FAIL;
      S_RCA:   if (mine) st_d = ok_q ? S_SEL : S_FAIL;
      S_SEL:   if (mine) st_d = !ok_q ? S_FAIL : (o_hc_card ? S_READY : S_BLEN);
      S_BLEN:  if (mine) st_d = ok_q ? S_READY : S_FAIL;
      S_READY: if (rd_take) st_d = S_RD;
      S_RD: begin
        // Leave once both the response and every block are
        if ((mine && !ok_q) || rx_crc || rx_to) begin
          st_d = S_STOP;
        end else if ((seen_q || (mine && ok_q))
                     && (left_q == 16'h0 || (left_q == 16'h1 && rx_done))) begin
          st_d = S_STOP;
        end
      end
      S_STOP:  if (mine) st_d = S_READY;
      S_FAIL:  st_d = S_FAIL;
      default: st_d = S_FAIL;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      st_q      <= S_WARM;
      issued_q  <= 1'b0;
      warm_q    <= '0;
      tries_q   <= '0;
      rca_q     <= '0;
      fast_q    <= 1'b0;
      o_hc_card <= 1'b0;
      rd_arg_q  <= '0;
      left_q    <= '0;
      multi_q   <= 1'b0;
      seen_q    <= 1'b0;
    end else if (i_ce) begin
      st_q     <= st_d;
      issued_q <= (st_d != st_q) ? 1'b0 : (issued_q || cmd_go);
      if (tick && st_q == S_WARM) warm_q <= warm_q + 8'd1;
      if (mine && st_q == S_OPC) begin
        tries_q   <= tries_q + 16'd1;
        o_hc_card <= resp_arg_q[OCR_CCS];
      end
      if (mine && st_q == S_RCA) rca_q <= resp_arg_q[31:16];
      if (mine && ok_q && st_q == S_SEL) fast_q <= 1'b1;
      if (rd_take) begin
        rd_arg_q <= o_hc_card ? i_rd_block : (i_rd_block << BLK_SHIFT);
        left_q   <= i_rd_count;
        multi_q  <= i_rd_count != 16'h1;
        seen_q   <= 1'b0;
      end else if (st_q == S_RD) begin
        if (mine) seen_q <= 1'b1;
        if (rx_done && left_q != 16'h0) left_q <= left_q - 16'd1;
      end
    end
  end

  // Errors stay until the next read is taken; a new event beats the clear
  assign err_ev = '{crc: rx_crc && st_q == S_RD,
                    timeout: (rx_to && st_q == S_RD) || (mine && to_q),
                    resp: mine && !ok_q && !to_q};
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_err        <= '0;
      o_ready      <= 1'b0;
      o_busy       <= 1'b1;
      o_sd_clk     <= 1'b0;
      o_sd_dat0_oe <= 1'b1;
      dat_out_q    <= 1'b1;
    end else if (i_ce) begin
      o_err        <= (rd_take ? '0 : o_err) | err_ev;
      o_ready      <= st_d == S_READY;
      o_busy       <= st_d != S_READY;
      o_sd_clk     <= sclk_q;
      o_sd_dat0_oe <= st_d == S_WARM;
      dat_out_q    <= 1'b1;
    end
  end
  assign o_sd_dat0 = dat_out_q;

  // Armed from the read command's start, so data racing the response is caught
  sdh_dat_rx #(.WAIT_CLKS(DATA_WAIT)) u_dat_rx (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .i_ce       (i_ce),
    .i_arm      (st_q == S_RD && left_q != 16'h0),
    .i_tick     (tick),
    .i_bit      (dat_s_q),
    .o_byte     (o_rd_byte),
    .o_blk_done (rx_done),
    .o_crc_bad  (rx_crc),
    .o_timeout  (rx_to)
  );
  assign o_blk_done = rx_done;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_warm_end;
    st_q == S_WARM ##1 st_q == S_CMD0;
  endsequence
  property p_warm_high;
    st_q == S_WARM |-> o_sd_cmd_oe && o_sd_cmd && o_sd_dat0_oe;
  endproperty
  a_warm_high: assert property (p_warm_high) else $error("lines not high in warmup");
  property p_first_cmd0;
    s_warm_end |-> warm_q == 8'(WARM_CLKS) && cmd_req.idx == IX_GO_IDLE;
  endproperty
  a_first_cmd0: assert property (p_first_cmd0) else $error("go-idle not first");
  property p_gap_released;
    eph_q inside {E_GAP, E_WAIT, E_RECV} |-> !o_sd_cmd_oe;
  endproperty
  a_gap_released: assert property (p_gap_released) else $error("cmd driven after frame");
  property p_gap_len;
    (eph_q == E_GAP && tick && wcnt_q == GAP_LAST) |=> eph_q != E_GAP;
  endproperty
  a_gap_len: assert property (p_gap_len) else $error("handover gap wrong");
  property p_start_bit;
    (eph_q == E_SEND && tick && bcnt_q == 8'd0) |=> o_sd_cmd_oe && !o_sd_cmd;
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("frame start bit wrong");
  property p_change_on_fall;
    $changed(o_sd_cmd) |-> $fell(sclk_q);
  endproperty
  a_change_on_fall: assert property (p_change_on_fall) else $error("cmd moved off fall");
  property p_crc_flag;
    (i_ce && rx_crc && st_q == S_RD) |=> o_err.crc ##1 o_err.crc;
  endproperty
  a_crc_flag: assert property (p_crc_flag) else $error("crc error not flagged");
  property p_read_stop;
    (i_ce && st_q == S_RD && st_d != S_RD) |=> st_q == S_STOP && cmd_req.idx == IX_STOP;
  endproperty
  a_read_stop: assert property (p_read_stop) else $error("read not ended by stop");
  property p_clk_idle;
    st_q inside {S_READY, S_FAIL} ##1 st_q inside {S_READY, S_FAIL} |-> !sclk_q;
  endproperty
  a_clk_idle: assert property (p_clk_idle) else $error("card clock not idle low");
endmodule

// >>> verification/sdh_card_model.sv
`timescale 1ns/100ps
module sdh_card_model (
  // Card side pins
  input  wire logic i_clk,
  input  wire logic i_cmd,
  output logic      o_cmd,
  output logic      o_cmd_oe,
  output logic      o_dat,
  output logic      o_dat_oe
);
  logic [7:0]  q[$];
  logic [37:0] seen[$];
  logic [31:0] arg;
  logic [47:0] f;
  bit          bad;
  bit          mute;
  bit          sdsc;
  int          nblk;
  int          tries;

  function automatic logic [47:0] rsp(input logic [5:0] ix, input logic [31:0] a);
    logic [6:0]  c;
    logic [39:0] d;
    d = {2'b00, ix, a};
    c = 7'h00;
    for (int i = 39; i >= 0; i--)
      c = {c[5:0], 1'b0} ^ ((c[6] ^ d[i]) ? 7'h09 : 7'h00);
    return {d, c, 1'b1};
  endfunction

  task automatic send(input logic [135:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(negedge i_clk);
      o_cmd_oe = 1'b1;
      o_cmd    = v[i];
    end
    @(negedge i_clk);
    o_cmd_oe = 1'b0;
  endtask

  task automatic blocks(input int n);
    logic [15:0] c;
    logic [7:0]  b;
    repeat (n) begin
      c = 16'h0000;
      repeat (2) @(negedge i_clk);
      o_dat_oe = 1'b1;
      o_dat    = 1'b0;
      repeat (512) begin
        b = q.pop_front();
        for (int i = 7; i >= 0; i--) begin
          @(negedge i_clk);
          o_dat = b[i];
          c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? 16'h1021 : 16'h0000);
        end
      end
      c[0] = c[0] ^ bad;
      for (int i = 15; i >= 0; i--) begin
        @(negedge i_clk);
        o_dat = c[i];
      end
      @(negedge i_clk);
      o_dat = 1'b1;
      @(negedge i_clk);
      o_dat_oe = 1'b0;
    end
  endtask

  initial begin
    o_cmd    = 1'b1;
    o_cmd_oe = 1'b0;
    o_dat    = 1'b1;
    o_dat_oe = 1'b0;
    forever begin
      do
        @(posedge i_clk);
      while (i_cmd !== 1'b0);
      f = 48'h0;
      for (int i = 46; i >= 0; i--) begin
        @(posedge i_clk);
        f[i] = i_cmd;
      end
      seen.push_back(f[45:8]);
      arg = f[39:8];
      // Both sides stay off the line for three clocks
      if (f[45:40] != 6'h00)
        repeat (3) @(negedge i_clk);
      case (f[45:40])
        6'h00: tries = 0;
        6'h29: begin
          tries++;
          send({2'b00, 6'h3f, tries > 1, !sdsc, 30'h00ff8000, 8'hff}, 48);
        end
        6'h02: send({8'h3f, 127'h1d41, 1'b1}, 136);
        6'h11, 6'h12: begin
          if (!mute)
            fork
              blocks(nblk);
            join_none
          send(rsp(f[45:40], arg), 48);
        end
        default: send(rsp(f[45:40], f[45:40] == 6'h03 ? 32'hb3680500 : arg), 48);
      endcase
    end
  end
endmodule

// >>> verification/sdh_native_host_read_tb.sv
`timescale 1ns/100ps
module sdh_native_host_read_tb
  import sdh_pkg::*;
;
  logic         clk = 1'b0, rst = 1'b1, ce = 1'b1, start = 1'b0;
  logic [31:0]  blk = 32'h0;
  logic [15:0]  cnt = 16'h0;
  logic         rdy, busy, hc, done, sclk, hcmd, hoe, hdat, hdoe, ccmd, coe, cdat, cdoe;
  sdh_byte_type rb;
  sdh_err_type  err;
  int           miscompares, checks, cyc, n;
  time          t0;
  // Card clock half period during identification, in core cycles
  localparam int ID_HALF = 3;
  logic [7:0]   r = 8'h5b;
  logic [7:0]   exp_q[$];
  logic [5:0]   ix[9] = '{6'h00, 6'h08, 6'h37, 6'h29, 6'h37, 6'h29, 6'h02, 6'h03, 6'h07};
  // Pull-ups hold both lines high when nobody drives
  wire cmd_w = hoe ? hcmd : coe ? ccmd : 1'b1;
  wire dat_w = hdoe ? hdat : cdoe ? cdat : 1'b1;

  always #5 clk = ~clk;

  sdh_host #(.DATA_WAIT(200), .OPC_LIMIT(16'h0005), .ID_HALF_LAST(8'(ID_HALF - 1))) u_sdh_host (
    .i_core_clk(clk), .i_sys_rst(rst), .i_ce(ce), .i_rd_start(start),
    .i_rd_block(blk), .i_rd_count(cnt), .o_ready(rdy), .o_busy(busy), .o_hc_card(hc),
    .o_rd_byte(rb), .o_blk_done(done), .o_err(err), .o_sd_clk(sclk), .i_sd_cmd(cmd_w),
    .o_sd_cmd(hcmd), .o_sd_cmd_oe(hoe), .i_sd_dat0(dat_w), .o_sd_dat0(hdat),
    .o_sd_dat0_oe(hdoe));

  sdh_card_model u_sdh_card_model (
    .i_clk(sclk), .i_cmd(cmd_w), .o_cmd(ccmd), .o_cmd_oe(coe), .o_dat(cdat), .o_dat_oe(cdoe));

  task automatic chk(input logic [39:0] g, input logic [39:0] x);
    checks++;
    if (g !== x) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  task automatic print_verdict();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic rd(input int nb, input bit bd, input bit mt, input logic [2:0] e);
    int got;
    u_sdh_card_model.bad  = bd;
    u_sdh_card_model.mute = mt;
    u_sdh_card_model.nblk = nb;
    u_sdh_card_model.q.delete();
    u_sdh_card_model.seen.delete();
    exp_q.delete();
    repeat (nb * 512) begin
      r = lfsr(r);
      exp_q.push_back(r);
      u_sdh_card_model.q.push_back(r);
    end
    @(posedge clk) #1;
    blk   = {24'h0, r};
    cnt   = 16'(nb);
    start = 1'b1;
    @(posedge clk) #1;
    start = 1'b0;
    got   = 0;
    chk(busy, 1'b1);
    while (rdy !== 1'b1) begin
      @(negedge clk);
      if (rb.valid === 1'b1)
        chk(rb.data, exp_q.pop_front());
      got += (done === 1'b1);
    end
    chk(busy, 1'b0);
    chk(err, e);
    if (!bd && !mt)
      chk(got, nb);
    chk(u_sdh_card_model.seen[0], {nb > 1 ? 6'h12 : 6'h11,
        u_sdh_card_model.sdsc ? blk << BLK_SHIFT : blk});
    chk(u_sdh_card_model.seen[1][37:32], 6'h0c);
  endtask

  always @(posedge clk) begin
    cyc++;
    // Both start-ups and five reads need roughly 85k cycles
    if (cyc == 95000) begin
      miscompares++;
      print_verdict();
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    n = 0;
    @(posedge sclk);
    t0 = $time;
    while (cmd_w === 1'b1 && dat_w === 1'b1) begin
      n++;
      @(posedge sclk);
    end
    // One more high clock passes while the first frame loads
    chk(n, 40'(WARM_CLKS + 1));
    chk(40'(($time - t0) / n), 40'(20 * ID_HALF));
    while (rdy !== 1'b1)
      @(negedge clk);
    for (int i = 0; i < 9; i++)
      chk(u_sdh_card_model.seen[i][37:32], ix[i]);
    chk(u_sdh_card_model.seen[8][31:0], 32'hb3680000);
    chk(hc, 1'b1);
    @(posedge clk) #1;
    start = 1'b1;
    repeat (3) @(negedge clk);
    chk(rdy, 1'b1);
    rd(1, 1'b0, 1'b0, 3'h0);
    rd(2, 1'b0, 1'b0, 3'h0);
    rd(1, 1'b1, 1'b0, 3'h4);
    rd(1, 1'b0, 1'b1, 3'h2);
    // Second start-up in mid-run against a byte-addressed card
    @(posedge clk) #1;
    rst = 1'b1;
    u_sdh_card_model.sdsc = 1'b1;
    u_sdh_card_model.seen.delete();
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    while (rdy !== 1'b1)
      @(negedge clk);
    chk(hc, 1'b0);
    chk(u_sdh_card_model.seen[9], {6'h10, 32'h0000_0200});
    rd(1, 1'b0, 1'b1, 3'h2);
    print_verdict();
  end
endmodule
